//--- src/dof_formatter.sv
// Purpose: output formatting and transmit logic of a dual-channel sampling converter
// Assumes: conversion results arrive on the link clock, new ones every two link cycles
// Notes:   apb slave on the system clock; pins and straps are synchronised to the link clock
//
// Function
// - offer ddr differential and parallel styles, chosen by register bit or strap
// - ddr style carries two bits per differential pair plus a differential clock
// - ddr: even bits with forwarded clock high, odd bits with it low
// - parallel style drives every bit on its own pin, one word per sample
// - multiplexed mode interleaves both channels onto channel a bus
// - multiplexed mode puts channel b pins in high impedance
// - multiplexed mode only exists in parallel style
// - multiplexed mode set by power-state field or three control pins
// - output code is twos complement or offset binary, by register bit or strap
// - positive overdrive gives 0x3fff offset binary, 0x1fff twos complement
// - negative overdrive gives 0x0000 offset binary, 0x2000 twos complement
// - power-state 1111 or all pins high selects mux, 0000 or low normal
// - forwarded clock stays aligned with the driven words in both styles
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module dof_formatter
    import dof_pkg::*;
(
    // system clock and reset
    input  wire logic                I_SYS_CLK,
    input  wire logic                I_RST_B,
    // apb slave
    input  wire logic                I_PSEL,
    input  wire logic                I_PENABLE,
    input  wire logic                I_PWRITE,
    input  wire logic [ADDR_W-1:0]   I_PADDR,
    input  wire logic [31:0]         I_PWDATA,
    output logic                     O_PREADY,
    output logic                     O_PSLVERR,
    output logic [31:0]              O_PRDATA,
    // link clock and reset
    input  wire logic                I_LINK_CLK,
    input  wire logic                I_LINK_RST_B,
    // conversion results from the converter core
    input  wire logic [SAMPLE_W-1:0] I_CHAN_A_RESULT,
    input  wire logic [SAMPLE_W-1:0] I_CHAN_B_RESULT,
    input  wire logic                I_CHAN_A_OVER_POS,
    input  wire logic                I_CHAN_A_OVER_NEG,
    input  wire logic                I_CHAN_B_OVER_POS,
    input  wire logic                I_CHAN_B_OVER_NEG,
    // configuration pins
    input  wire logic                I_PAR_CFG_MODE,
    input  wire logic [1:0]          I_FORMAT_STRAP_PIN,
    input  wire logic [2:0]          I_PARALLEL_CONTROL_PINS,
    // parallel single-ended outputs
    output logic [SAMPLE_W-1:0]      O_CHAN_A_BUS,
    output logic                     O_CHAN_A_OE_B,
    output logic [SAMPLE_W-1:0]      O_CHAN_B_BUS,
    output logic                     O_CHAN_B_OE_B,
    output logic                     O_SINGLE_ENDED_FWD_CLOCK,
    // ddr differential outputs
    output logic [LANE_W-1:0]        O_DDR_A_LANE_POS,
    output logic [LANE_W-1:0]        O_DDR_A_LANE_NEG,
    output logic [LANE_W-1:0]        O_DDR_B_LANE_POS,
    output logic [LANE_W-1:0]        O_DDR_B_LANE_NEG,
    output logic                     O_DDR_OE_B,
    output logic                     O_FWD_CLOCK_POS,
    output logic                     O_FWD_CLOCK_NEG
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // raw results are offset binary; twos complement flips the msb
    function automatic logic [SAMPLE_W-1:0] fmt_code(
        input logic [SAMPLE_W-1:0] raw,
        input logic                pos,
        input logic                neg,
        input logic                ob
    );
        logic [SAMPLE_W-1:0] res;
        res = ob ? raw : {~raw[SAMPLE_W-1], raw[SAMPLE_W-2:0]};
        if (pos)
        begin
            res = ob ? OB_POS_FS : TC_POS_FS;
        end
        else if (neg)
        begin
            res = ob ? OB_NEG_FS : TC_NEG_FS;
        end
        return res;
    endfunction : fmt_code

    // ----------------------------------------------------------------
    // system clock side: apb registers
    // ----------------------------------------------------------------
    dof_sys_t  sys_reg;
    dof_sys_t  sys_next;
    // declared here because the status synchroniser below reads it
    dof_link_t link_reg;
    logic     setup_cyc;
    logic     done_cyc;
    logic     hit_ctrl;
    logic     hit_stat;

    assign setup_cyc = I_PSEL && !I_PENABLE;
    assign done_cyc  = I_PSEL && I_PENABLE && sys_reg.pready;
    assign hit_ctrl  = (I_PADDR == CTRL_OFS);
    assign hit_stat  = (I_PADDR == STATUS_OFS);

    always_comb
    begin
        sys_next         = sys_reg;
        sys_next.stat_s1 = link_reg.eff;
        sys_next.stat_s2 = sys_reg.stat_s1;
        // answer is prepared in the setup cycle so pready is a flop
        if (setup_cyc)
        begin
            sys_next.pready  = 1'b1;
            sys_next.pslverr = !(hit_ctrl || hit_stat);
            sys_next.prdata  = 32'h0000_0000;
            if (!I_PWRITE && hit_ctrl)
            begin
                sys_next.prdata = sys_reg.ctrl;
            end
            else if (!I_PWRITE && hit_stat)
            begin
                sys_next.prdata = {{(32-STAT_W){1'b0}}, sys_reg.stat_s2};
            end
        end
        else if (done_cyc)
        begin
            sys_next.pready  = 1'b0;
            sys_next.pslverr = 1'b0;
            if (I_PWRITE && hit_ctrl)
            begin
                sys_next.ctrl = {24'h000000, I_PWDATA[7:4], 2'h0, I_PWDATA[1:0]};
            end
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RST_B)
        begin
            sys_reg         <= '0;
            sys_reg.ctrl    <= CTRL_RESET;
        end
        else
        begin
            sys_reg <= sys_next;
        end
    end

    assign O_PREADY  = sys_reg.pready;
    assign O_PSLVERR = sys_reg.pslverr;
    assign O_PRDATA  = sys_reg.prdata;

    // ----------------------------------------------------------------
    // link clock side: mode resolution and transmit
    // ----------------------------------------------------------------
    dof_link_t           link_next;
    logic                par_cfg;
    logic                style_par;
    logic                fmt_ob;
    logic [PMODE_W-1:0]  pmode;
    logic                mux_on;
    logic                a_on;
    logic                b_on;
    logic                a_live;
    logic                b_live;
    logic [SAMPLE_W-1:0] hi_a;
    logic [SAMPLE_W-1:0] hi_b;
    logic [2:0]          pins;

    always_comb
    begin
        par_cfg = link_reg.pin_s2[5];
        pins    = link_reg.pin_s2[2:0];
        // style from strap in parallel configuration
        style_par = par_cfg ? link_reg.pin_s2[3] : link_reg.cfg_s2[0];
        fmt_ob = par_cfg ? link_reg.pin_s2[4] : link_reg.cfg_s2[1];
        // power state from pins or register field
        // all pins low is normal, otherwise the code has its msb set
        pmode = par_cfg ? ((pins == 3'h0) ? PM_NORMAL : {1'b1, pins}) : link_reg.cfg_s2[5:2];
        // mux exists only in parallel style
        mux_on = style_par && (pmode == PM_MUX);
        a_on   = !(pmode inside {PM_A_OFF, PM_AB_OFF, PM_GLOBAL_PD});
        b_on   = !(pmode inside {PM_B_OFF, PM_AB_OFF, PM_GLOBAL_PD});
        a_live = (pmode != PM_A_STBY);
        b_live = (pmode != PM_B_STBY);
    end

    always_comb
    begin
        link_next        = link_reg;
        link_next.cfg_s1 = {sys_reg.ctrl[CTRL_PMODE_LSB +: PMODE_W],
                            sys_reg.ctrl[CTRL_FORMAT_BIT], sys_reg.ctrl[CTRL_STYLE_BIT]};
        link_next.cfg_s2 = link_reg.cfg_s1;
        link_next.pin_s1 = {I_PAR_CFG_MODE, I_FORMAT_STRAP_PIN[1], I_FORMAT_STRAP_PIN[0],
                            I_PARALLEL_CONTROL_PINS};
        link_next.pin_s2 = link_reg.pin_s1;
        link_next.eff    = {b_on && !mux_on, a_on, mux_on, fmt_ob, style_par};
        link_next.phase  = !link_reg.phase;
        // capture both channels of one instant at the end of a sample period
        if (link_reg.phase)
        begin
            link_next.word_a = a_live ? fmt_code(I_CHAN_A_RESULT, I_CHAN_A_OVER_POS,
                                                 I_CHAN_A_OVER_NEG, fmt_ob) : '0;
            link_next.word_b = b_live ? fmt_code(I_CHAN_B_RESULT, I_CHAN_B_OVER_POS,
                                                 I_CHAN_B_OVER_NEG, fmt_ob) : '0;
        end
        hi_a = link_reg.word_a;
        hi_b = link_reg.word_b;
        // clock high in first half of each sample period
        link_next.fwd_clk = !link_reg.phase;
        link_next.se_clk  = style_par && !link_reg.phase;
        link_next.ddr_on  = !style_par && (a_on || b_on);
        // two bits per lane per sample
        for (int i = 0; i < LANE_W; i++)
        begin
            // even bits while high, odd bits while low
            link_next.lane_a[i] = style_par ? 1'b0 : hi_a[2*i + (link_reg.phase ? 1 : 0)];
            link_next.lane_b[i] = style_par ? 1'b0 : hi_b[2*i + (link_reg.phase ? 1 : 0)];
        end
        // one full word per pin group per sample
        link_next.bus_a = style_par ? hi_a : '0;
        link_next.bus_b = (style_par && !mux_on) ? hi_b : '0;
        // second half of the period carries channel b on bus a
        // channel a first, then channel b
        if (mux_on && link_reg.phase)
        begin
            link_next.bus_a = hi_b;
        end
        link_next.oe_a_b = !(style_par && a_on);
        // channel b released in mux mode
        link_next.oe_b_b = !(style_par && b_on && !mux_on);
    end

    always_ff @(posedge I_LINK_CLK)
    begin
        if (!I_LINK_RST_B)
        begin
            link_reg        <= '0;
            link_reg.oe_a_b <= 1'b1;
            link_reg.oe_b_b <= 1'b1;
        end
        else
        begin
            link_reg <= link_next;
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    assign O_CHAN_A_BUS             = link_reg.bus_a;
    assign O_CHAN_A_OE_B            = link_reg.oe_a_b;
    assign O_CHAN_B_BUS             = link_reg.bus_b;
    assign O_CHAN_B_OE_B            = link_reg.oe_b_b;
    assign O_SINGLE_ENDED_FWD_CLOCK = link_reg.se_clk;
    assign O_DDR_A_LANE_POS         = link_reg.lane_a;
    assign O_DDR_A_LANE_NEG         = ~link_reg.lane_a;
    assign O_DDR_B_LANE_POS         = link_reg.lane_b;
    assign O_DDR_B_LANE_NEG         = ~link_reg.lane_b;
    assign O_DDR_OE_B               = !link_reg.ddr_on;
    assign O_FWD_CLOCK_POS          = link_reg.fwd_clk;
    assign O_FWD_CLOCK_NEG          = !link_reg.fwd_clk;

endmodule : dof_formatter

`default_nettype wire

//--- src/dof_pkg.sv
// Purpose: shared constants and state types of the dual-channel output formatter
// Assumes: APB register file on the system clock, output logic on the link clock
// Notes:   the link clock runs at twice the sample rate, two link cycles per sample
package dof_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int unsigned SAMPLE_W = 14;
    localparam int unsigned LANE_W   = SAMPLE_W / 2;
    localparam int unsigned PMODE_W  = 4;
    localparam int unsigned ADDR_W   = 12;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;

    // control register fields
    localparam int unsigned CTRL_STYLE_BIT  = 0;
    localparam int unsigned CTRL_FORMAT_BIT = 1;
    localparam int unsigned CTRL_PMODE_LSB  = 4;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

    // status register fields
    localparam int unsigned STAT_STYLE_BIT  = 0;
    localparam int unsigned STAT_FORMAT_BIT = 1;
    localparam int unsigned STAT_MUX_BIT    = 2;
    localparam int unsigned STAT_A_ON_BIT   = 3;
    localparam int unsigned STAT_B_ON_BIT   = 4;
    localparam int unsigned STAT_W          = 5;

    // ----------------------------------------------------------------
    // power-state codes
    // ----------------------------------------------------------------
    localparam logic [PMODE_W-1:0] PM_NORMAL    = 4'h0;
    localparam logic [PMODE_W-1:0] PM_B_OFF     = 4'h9;
    localparam logic [PMODE_W-1:0] PM_A_OFF     = 4'ha;
    localparam logic [PMODE_W-1:0] PM_AB_OFF    = 4'hb;
    localparam logic [PMODE_W-1:0] PM_GLOBAL_PD = 4'hc;
    localparam logic [PMODE_W-1:0] PM_B_STBY    = 4'hd;
    localparam logic [PMODE_W-1:0] PM_A_STBY    = 4'he;
    localparam logic [PMODE_W-1:0] PM_MUX       = 4'hf;

    // ----------------------------------------------------------------
    // overdrive codes
    // ----------------------------------------------------------------
    localparam logic [SAMPLE_W-1:0] OB_POS_FS = 14'h3fff;
    localparam logic [SAMPLE_W-1:0] OB_NEG_FS = 14'h0000;
    localparam logic [SAMPLE_W-1:0] TC_POS_FS = 14'h1fff;
    localparam logic [SAMPLE_W-1:0] TC_NEG_FS = 14'h2000;

    // ----------------------------------------------------------------
    // state of the system-clock side
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0]       ctrl;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic [STAT_W-1:0] stat_s1;
        logic [STAT_W-1:0] stat_s2;
    } dof_sys_t;

    // ----------------------------------------------------------------
    // state of the link-clock side
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [5:0]          cfg_s1;
        logic [5:0]          cfg_s2;
        logic [5:0]          pin_s1;
        logic [5:0]          pin_s2;
        logic                phase;
        logic [SAMPLE_W-1:0] word_a;
        logic [SAMPLE_W-1:0] word_b;
        logic [STAT_W-1:0]   eff;
        logic [SAMPLE_W-1:0] bus_a;
        logic [SAMPLE_W-1:0] bus_b;
        logic                oe_a_b;
        logic                oe_b_b;
        logic [LANE_W-1:0]   lane_a;
        logic [LANE_W-1:0]   lane_b;
        logic                ddr_on;
        logic                fwd_clk;
        logic                se_clk;
    } dof_link_t;

endpackage : dof_pkg

//--- dv/dof_formatter_props.sv
// Purpose: concurrent checks on the output formatter ports
// Assumes: the capture edge is the link edge that samples the forwarded clock high
// Notes:   overdrive codes share their low 13 bits in both formats
`timescale 1ns/1ns
`default_nettype none
module dof_formatter_props
    import dof_pkg::*;
(
    // system side
    input  wire logic                I_SYS_CLK,
    input  wire logic                I_RST_B,
    input  wire logic                I_PSEL,
    input  wire logic                I_PENABLE,
    input  wire logic [ADDR_W-1:0]   I_PADDR,
    input  wire logic                O_PREADY,
    input  wire logic                O_PSLVERR,
    // link side
    input  wire logic                I_LINK_CLK,
    input  wire logic                I_LINK_RST_B,
    input  wire logic [SAMPLE_W-1:0] I_CHAN_A_RESULT,
    input  wire logic                I_CHAN_A_OVER_POS,
    input  wire logic                I_CHAN_A_OVER_NEG,
    input  wire logic [SAMPLE_W-1:0] O_CHAN_A_BUS,
    input  wire logic                O_CHAN_A_OE_B,
    input  wire logic                O_SINGLE_ENDED_FWD_CLOCK,
    input  wire logic [LANE_W-1:0]   O_DDR_A_LANE_POS,
    input  wire logic [LANE_W-1:0]   O_DDR_A_LANE_NEG,
    input  wire logic                O_DDR_OE_B,
    input  wire logic                O_FWD_CLOCK_POS,
    input  wire logic                O_FWD_CLOCK_NEG
);
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    function automatic logic [LANE_W-1:0] evn(input logic [SAMPLE_W-1:0] r);
        for (int i = 0; i < LANE_W; i++)
            evn[i] = r[2*i];
    endfunction : evn
    sequence s_setup;
        I_PSEL && !I_PENABLE;
    endsequence
    sequence s_cap;
        O_FWD_CLOCK_POS;
    endsequence
    a_pready_setup: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
        s_setup |=> O_PREADY) else $error("pready missing after setup");
    a_pready_pulse: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
        O_PREADY |=> !O_PREADY) else $error("pready held too long");
    a_unmapped_err: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_B)
        s_setup ##0 (I_PADDR != CTRL_OFS && I_PADDR != STATUS_OFS) |=> O_PSLVERR && O_PREADY)
        else $error("no error on unmapped address");
    a_fwd_toggle: assert property (@(posedge I_LINK_CLK) disable iff (!I_LINK_RST_B)
        $past(I_LINK_RST_B, 2) |-> O_FWD_CLOCK_POS != $past(O_FWD_CLOCK_POS)
        && O_FWD_CLOCK_NEG == !O_FWD_CLOCK_POS) else $error("forwarded clock not toggling");
    a_lane_pair: assert property (@(posedge I_LINK_CLK) disable iff (!I_LINK_RST_B)
        O_DDR_A_LANE_NEG == ~O_DDR_A_LANE_POS) else $error("lane pair not complementary");
    a_ddr_quiet: assert property (@(posedge I_LINK_CLK) disable iff (!I_LINK_RST_B)
        O_DDR_OE_B |-> O_DDR_A_LANE_POS == '0) else $error("lanes active while released");
    a_se_clk_ddr: assert property (@(posedge I_LINK_CLK) disable iff (!I_LINK_RST_B)
        !O_DDR_OE_B |-> !O_SINGLE_ENDED_FWD_CLOCK) else $error("parallel clock runs in ddr");
    a_pos_over: assert property (@(posedge I_LINK_CLK) disable iff (!I_LINK_RST_B)
        s_cap ##0 I_CHAN_A_OVER_POS |-> ##2 (O_CHAN_A_OE_B || O_CHAN_A_BUS[12:0] == 13'h1fff))
        else $error("wrong positive overdrive code");
    a_neg_over: assert property (@(posedge I_LINK_CLK) disable iff (!I_LINK_RST_B)
        s_cap ##0 (I_CHAN_A_OVER_NEG && !I_CHAN_A_OVER_POS)
        |-> ##2 (O_CHAN_A_OE_B || O_CHAN_A_BUS[12:0] == 13'h0000))
        else $error("wrong negative overdrive code");
    a_ddr_even: assert property (@(posedge I_LINK_CLK) disable iff (!I_LINK_RST_B)
        s_cap ##0 (!O_DDR_OE_B && !I_CHAN_A_OVER_POS && !I_CHAN_A_OVER_NEG)
        |-> ##2 (O_DDR_OE_B || O_DDR_A_LANE_POS == evn($past(I_CHAN_A_RESULT, 2))))
        else $error("even bits missing in first half");
endmodule : dof_formatter_props
bind dof_formatter dof_formatter_props u_props (
    .I_SYS_CLK, .I_RST_B, .I_PSEL, .I_PENABLE, .I_PADDR, .O_PREADY, .O_PSLVERR,
    .I_LINK_CLK, .I_LINK_RST_B, .I_CHAN_A_RESULT, .I_CHAN_A_OVER_POS, .I_CHAN_A_OVER_NEG,
    .O_CHAN_A_BUS, .O_CHAN_A_OE_B, .O_SINGLE_ENDED_FWD_CLOCK, .O_DDR_A_LANE_POS,
    .O_DDR_A_LANE_NEG, .O_DDR_OE_B, .O_FWD_CLOCK_POS, .O_FWD_CLOCK_NEG
);
`default_nettype wire

//--- dv/dof_capture_model.sv
// Purpose: receive-side capture of the ddr lanes and parallel buses
// Assumes: a copy of the link clock serves as the delayed capture clock
// Notes:   samples mid-cell on the falling link edge, clear of output changes
`timescale 1ns/1ns
`default_nettype none
module dof_capture_model
    import dof_pkg::*;
(
    // capture clock and wires
    input  wire logic                i_link_clk,
    input  wire logic                i_fwd,
    input  wire logic [LANE_W-1:0]   i_lane_a,
    input  wire logic [LANE_W-1:0]   i_lane_b,
    input  wire logic [SAMPLE_W-1:0] i_bus_a,
    input  wire logic [SAMPLE_W-1:0] i_bus_b,
    input  wire logic                i_oe_a_b,
    input  wire logic                i_oe_b_b,
    // recovered words
    output logic      [SAMPLE_W-1:0] o_wa0,
    output logic      [SAMPLE_W-1:0] o_wa1,
    output logic      [SAMPLE_W-1:0] o_wb,
    output logic      [SAMPLE_W-1:0] o_da,
    output logic      [SAMPLE_W-1:0] o_db
);
    logic [LANE_W-1:0] ev_a;
    logic [LANE_W-1:0] ev_b;
    function automatic logic [SAMPLE_W-1:0] mix(input logic [LANE_W-1:0] e, o);
        for (int i = 0; i < LANE_W; i++)
            mix[2*i+:2] = {o[i], e[i]};
    endfunction : mix
    // both halves captured for the lanes and bus a; bus b only while the forwarded clock is high
    // a released bus reads inverted so a stale word never passes
    always @(negedge i_link_clk)
    begin
        if (i_fwd)
        begin
            ev_a <= i_lane_a;
            ev_b <= i_lane_b;
            o_wa0 <= i_oe_a_b ? ~o_wa0 : i_bus_a;
            o_wb <= i_oe_b_b ? ~o_wb : i_bus_b;
        end
        else
        begin
            o_da <= mix(ev_a, i_lane_a);
            o_db <= mix(ev_b, i_lane_b);
            o_wa1 <= i_oe_a_b ? ~o_wa1 : i_bus_a;
        end
    end
endmodule : dof_capture_model
`default_nettype wire

//--- dv/dof_formatter_test.sv
// Purpose: self-checking bench of the dual-channel output formatter
// Assumes: link clock 125 ns, system clock 10 ns, unrelated phases
// Notes:   each row holds its inputs for ten link cycles before the compares
`timescale 1ns/1ns
`default_nettype none
module dof_formatter_test
    import dof_pkg::*;
;
    typedef struct packed {
        logic       mode;
        logic [1:0] strap;
        logic [2:0] pins;
        logic [7:0] ctrl;
        logic [3:0] ov;
        logic [2:0] oe;
    } dof_row_t;
    logic I_SYS_CLK = 1'h0, I_RST_B = 1'h0, I_PSEL = 1'h0, I_PENABLE = 1'h0, I_PWRITE = 1'h0;
    logic I_LINK_CLK = 1'h0, I_LINK_RST_B = 1'h0, I_PAR_CFG_MODE = 1'h0;
    logic I_CHAN_A_OVER_POS = 1'h0, I_CHAN_A_OVER_NEG = 1'h0;
    logic I_CHAN_B_OVER_POS = 1'h0, I_CHAN_B_OVER_NEG = 1'h0;
    logic [ADDR_W-1:0]   I_PADDR = '0;
    logic [31:0]         I_PWDATA = '0, O_PRDATA, rd;
    logic [SAMPLE_W-1:0] I_CHAN_A_RESULT = '0, I_CHAN_B_RESULT = '0, O_CHAN_A_BUS, O_CHAN_B_BUS;
    logic [1:0]          I_FORMAT_STRAP_PIN = '0;
    logic [2:0]          I_PARALLEL_CONTROL_PINS = '0;
    logic [LANE_W-1:0]   O_DDR_A_LANE_POS, O_DDR_A_LANE_NEG, O_DDR_B_LANE_POS, O_DDR_B_LANE_NEG;
    logic                O_PREADY, O_PSLVERR, O_CHAN_A_OE_B, O_CHAN_B_OE_B, O_DDR_OE_B, er;
    logic                O_SINGLE_ENDED_FWD_CLOCK, O_FWD_CLOCK_POS, O_FWD_CLOCK_NEG, par, ob;
    logic [SAMPLE_W-1:0] wa0, wa1, wb, da, db, ra, rb, ea, eb;
    logic [PMODE_W-1:0]  pm;
    dof_row_t            r;
    int                  error_cnt = 0;
    int                  tests_run = 0;
    // rows: pin or register config, overdrive flags, expected enables {a, b, ddr}
    dof_row_t rows [16] = '{
        '{1'h1, 2'h0, 3'h0, 8'h00, 4'h0, 3'h6}, '{1'h1, 2'h2, 3'h0, 8'h00, 4'h0, 3'h6},
        '{1'h1, 2'h3, 3'h0, 8'h00, 4'h0, 3'h1}, '{1'h1, 2'h1, 3'h0, 8'h00, 4'h9, 3'h1},
        '{1'h1, 2'h3, 3'h0, 8'h00, 4'h6, 3'h1}, '{1'h1, 2'h1, 3'h0, 8'h00, 4'hc, 3'h1},
        '{1'h1, 2'h3, 3'h7, 8'h00, 4'h0, 3'h3}, '{1'h1, 2'h0, 3'h7, 8'h00, 4'h0, 3'h6},
        '{1'h1, 2'h3, 3'h1, 8'h00, 4'h0, 3'h3}, '{1'h1, 2'h3, 3'h2, 8'h00, 4'h0, 3'h5},
        '{1'h1, 2'h3, 3'h3, 8'h00, 4'h0, 3'h7}, '{1'h1, 2'h3, 3'h4, 8'h00, 4'h0, 3'h7},
        '{1'h1, 2'h3, 3'h5, 8'h00, 4'h0, 3'h1}, '{1'h1, 2'h3, 3'h6, 8'h00, 4'h0, 3'h1},
        '{1'h0, 2'h0, 3'h0, 8'hf1, 4'h0, 3'h3}, '{1'h0, 2'h0, 3'h0, 8'h02, 4'h0, 3'h6}};
    always #5 I_SYS_CLK = ~I_SYS_CLK;
    // sample rate far below both limits
    always
    begin
        #62 I_LINK_CLK = 1'h1;
        #63 I_LINK_CLK = 1'h0;
    end
    dof_formatter dut (.*);
    dof_capture_model cap (.i_link_clk(I_LINK_CLK), .i_fwd(O_FWD_CLOCK_POS),
        .i_lane_a(O_DDR_A_LANE_POS), .i_lane_b(O_DDR_B_LANE_POS), .i_bus_a(O_CHAN_A_BUS),
        .i_bus_b(O_CHAN_B_BUS), .i_oe_a_b(O_CHAN_A_OE_B), .i_oe_b_b(O_CHAN_B_OE_B),
        .o_wa0(wa0), .o_wa1(wa1), .o_wb(wb), .o_da(da), .o_db(db));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge I_SYS_CLK);
        {I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA} <= {1'h1, 1'h0, w, a, d};
        @(posedge I_SYS_CLK);
        I_PENABLE <= 1'h1;
        do
        begin
            @(posedge I_SYS_CLK);
            n++;
        end while (O_PREADY !== 1'h1 && n < 20);
        if (O_PREADY !== 1'h1)
            error_cnt++;
        rd = O_PRDATA;
        er = O_PSLVERR;
        {I_PSEL, I_PENABLE} <= 2'h0;
    endtask : apb
    function automatic logic [SAMPLE_W-1:0] code(input logic [SAMPLE_W-1:0] v, input logic p, n, o);
        logic [SAMPLE_W-1:0] w;
        w = p ? OB_POS_FS : (n ? OB_NEG_FS : v);
        return o ? w : w ^ 14'h2000;
    endfunction : code
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (2) @(posedge I_SYS_CLK);
        I_RST_B <= 1'h1;
        repeat (3) @(posedge I_LINK_CLK);
        chk("oe_rst", 32'h7, 32'({O_CHAN_A_OE_B, O_CHAN_B_OE_B, O_DDR_OE_B}));
        chk("clk_rst", 32'h1, 32'({O_FWD_CLOCK_POS, O_FWD_CLOCK_NEG}));
        I_LINK_RST_B <= 1'h1;
        apb(1'h0, CTRL_OFS, 32'h0);
        chk("ctrl_rst", CTRL_RESET, rd);
        foreach (rows[i])
        begin
            r = rows[i];
            ra = 14'h0a5c + 14'(i * 521);
            rb = 14'h3193 - 14'(i * 307);
            apb(1'h1, CTRL_OFS, {24'h0, r.ctrl});
            @(posedge I_LINK_CLK);
            {I_PAR_CFG_MODE, I_FORMAT_STRAP_PIN, I_PARALLEL_CONTROL_PINS} <= {r.mode, r.strap, r.pins};
            {I_CHAN_A_RESULT, I_CHAN_B_RESULT} <= {ra, rb};
            {I_CHAN_A_OVER_POS, I_CHAN_A_OVER_NEG, I_CHAN_B_OVER_POS, I_CHAN_B_OVER_NEG} <= r.ov;
            repeat (10) @(posedge I_LINK_CLK);
            par = r.mode ? r.strap[0] : r.ctrl[0];
            ob = r.mode ? r.strap[1] : r.ctrl[1];
            pm = r.mode ? (r.pins == 3'h0 ? PM_NORMAL : {1'h1, r.pins}) : r.ctrl[7:4];
            ea = (pm == PM_A_STBY) ? '0 : code(ra, r.ov[3], r.ov[2], ob);
            eb = (pm == PM_B_STBY) ? '0 : code(rb, r.ov[1], r.ov[0], ob);
            chk("oe", 32'(r.oe), 32'({O_CHAN_A_OE_B, O_CHAN_B_OE_B, O_DDR_OE_B}));
            if (!par)
            begin
                chk("ddr_a", 32'(ea), 32'(da));
                chk("ddr_b", 32'(eb), 32'(db));
            end
            if (par && !r.oe[2])
            begin
                chk("bus_a0", 32'(ea), 32'(wa0));
                chk("bus_a1", 32'(pm == PM_MUX ? eb : ea), 32'(wa1));
            end
            if (par && !r.oe[1])
                chk("bus_b", 32'(eb), 32'(wb));
        end
        apb(1'h1, CTRL_OFS, 32'hffff_ffff);
        apb(1'h0, CTRL_OFS, 32'h0);
        chk("ctrl_rw", 32'h0000_00f3, rd);
        repeat (6) @(posedge I_LINK_CLK);
        apb(1'h1, STATUS_OFS, 32'h0);
        apb(1'h0, STATUS_OFS, 32'h0);
        chk("status_mux", 32'h0000_000f, rd);
        apb(1'h1, CTRL_OFS, 32'h0000_00f0);
        repeat (6) @(posedge I_LINK_CLK);
        apb(1'h0, STATUS_OFS, 32'h0);
        chk("mux_in_ddr", 32'h0, rd & 32'h4);
        apb(1'h0, 12'h008, 32'h0);
        chk("unmapped", 32'h2, 32'({er, |rd}));
        close_out();
    end
    initial
    begin
        #100000;
        error_cnt++;
        close_out();
    end
endmodule : dof_formatter_test
`default_nettype wire
